// File: rtl/sbsf_line_sync.sv
`timescale 1ns/1ps

module sbsf_line_sync (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic line_in,
    output logic line_out
);

    logic s1_reg;
    logic s2_reg;
    logic s3_reg;
    logic out_reg;
    logic out_next;

    // Level changes only once the two later stages agree
    always_comb begin
        out_next = (s2_reg == s3_reg) ? s2_reg : out_reg;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_reg <= 1'b1;
            s2_reg <= 1'b1;
            s3_reg <= 1'b1;
            out_reg <= 1'b1;
        end else begin
            s1_reg <= line_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            out_reg <= out_next;
        end
    end

    assign line_out = out_reg;

endmodule : sbsf_line_sync

// File: rtl/sbsf_pkg.sv
package sbsf_pkg;

    typedef enum logic [0:0] {
        SBSF_TX_IDLE,
        SBSF_TX_SHIFT
    } sbsf_tx_state_type;

    typedef enum logic [1:0] {
        SBSF_RX_IDLE,
        SBSF_RX_START,
        SBSF_RX_DATA,
        SBSF_RX_STOP
    } sbsf_rx_state_type;

    typedef struct packed {
        logic tx_empty;
        logic rx_full;
    } sbsf_flags_type;

endpackage : sbsf_pkg

// File: rtl/sbsf_regs.svh
`ifndef SBSF_REGS_SVH
`define SBSF_REGS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define SBSF_CTRL_OFF 8'h00
`define SBSF_STATUS_OFF 8'h04
`define SBSF_THR_OFF 8'h08
`define SBSF_RHR_OFF 8'h0C
`define SBSF_INT_STAT_OFF 8'h10
`define SBSF_INT_MASK_OFF 8'h14

// ****************************************************************
// Field positions
// ****************************************************************
`define SBSF_CTRL_TXEN_BIT 0
`define SBSF_CTRL_RE_BIT 1
`define SBSF_STATUS_TXE_BIT 7
`define SBSF_STATUS_RXF_BIT 6
`define SBSF_INT_TX_BIT 0
`define SBSF_INT_RX_BIT 1

// ****************************************************************
// Reset values
// ****************************************************************
`define SBSF_CTRL_RST 2'h0
`define SBSF_RHR_RST 8'h00
`define SBSF_THR_RST 8'h00
`define SBSF_INT_RST 2'h0

// ****************************************************************
// Timing
// ****************************************************************
`define SBSF_CLK_NS 10
`define SBSF_BIT_NS 1000
`define SBSF_BIT_CYCLES (`SBSF_BIT_NS / `SBSF_CLK_NS)
`define SBSF_HALF_CYCLES (`SBSF_BIT_CYCLES / 2)

`endif

// File: rtl/sbsf_serial_flags.sv
`timescale 1ns/1ps
`include "sbsf_regs.svh"

// How it works
// - Empty flag at zero means holding register data still awaits the shifter.
// - Software clears empty flag by writing zero only after reading it as one.
// - Writing the transmit holding register clears the empty flag.
// - Empty flag is forced to one while transmit enable is zero.
// - Empty flag sets when holding data moves into the shift register, unless the holding register is written in that same cycle.
// - Flag writes can only clear; writing one is ignored.

module sbsf_serial_flags
    import sbsf_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rxd,
    output logic txd,
    output logic irq
);

    // ****************************************************************
    // Declarations
    // ****************************************************************
    logic [1:0] ctrl_reg, ctrl_next;
    sbsf_flags_type flags_reg, flags_next;
    sbsf_flags_type arm_reg, arm_next;
    logic [7:0] thr_reg, thr_next;
    logic [7:0] rhr_reg, rhr_next;
    logic [1:0] int_stat_reg, int_stat_next;
    logic [1:0] int_mask_reg, int_mask_next;
    logic irq_reg, irq_next;
    logic pready_reg, pready_next;
    logic pslverr_reg, pslverr_next;
    logic [31:0] prdata_reg, prdata_next;

    sbsf_tx_state_type tx_state_reg, tx_state_next;
    logic [8:0] tx_shift_reg, tx_shift_next;
    logic [3:0] tx_bit_reg, tx_bit_next;
    logic [7:0] tx_cnt_reg, tx_cnt_next;
    logic txd_reg, txd_next;

    sbsf_rx_state_type rx_state_reg, rx_state_next;
    logic [7:0] rx_shift_reg, rx_shift_next;
    logic [3:0] rx_bit_reg, rx_bit_next;
    logic [7:0] rx_cnt_reg, rx_cnt_next;

    logic rxd_f;
    logic setup;
    logic acc;
    logic wr;
    logic rd;
    logic mapped;
    logic tx_en;
    logic re;
    logic tx_load;
    logic rx_done;
    logic [1:0] events;

    localparam logic [7:0] BIT_CYC = 8'(`SBSF_BIT_CYCLES - 1);
    localparam logic [7:0] HALF_CYC = 8'(`SBSF_HALF_CYCLES - 1);

    // ****************************************************************
    // Receive line synchroniser
    // ****************************************************************
    sbsf_line_sync u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .line_in(rxd),
        .line_out(rxd_f)
    );

    // ****************************************************************
    // Bus decode
    // ****************************************************************
    always_comb begin
        setup = psel && !penable;
        acc = psel && penable && pready_reg;
        wr = acc && pwrite;
        rd = acc && !pwrite;
        tx_en = ctrl_reg[`SBSF_CTRL_TXEN_BIT];
        re = ctrl_reg[`SBSF_CTRL_RE_BIT];
        mapped = (paddr == `SBSF_CTRL_OFF) || (paddr == `SBSF_STATUS_OFF)
              || (paddr == `SBSF_THR_OFF) || (paddr == `SBSF_RHR_OFF)
              || (paddr == `SBSF_INT_STAT_OFF) || (paddr == `SBSF_INT_MASK_OFF);
    end

    // Answer is prepared in setup so the access phase completes at once
    always_comb begin
        pready_next = setup;
        pslverr_next = setup ? !mapped : 1'b0;
        prdata_next = prdata_reg;
        if (setup) begin
            prdata_next = 32'h0;
            unique case (paddr)
                `SBSF_CTRL_OFF: begin
                    prdata_next[1:0] = ctrl_reg;
                end
                `SBSF_STATUS_OFF: begin
                    prdata_next[`SBSF_STATUS_TXE_BIT] = flags_reg.tx_empty || !tx_en;
                    prdata_next[`SBSF_STATUS_RXF_BIT] = flags_reg.rx_full;
                end
                `SBSF_RHR_OFF: begin
                    prdata_next[7:0] = rhr_reg;
                end
                `SBSF_INT_STAT_OFF: begin
                    prdata_next[1:0] = int_stat_reg;
                end
                `SBSF_INT_MASK_OFF: begin
                    prdata_next[1:0] = int_mask_reg;
                end
                default: begin
                    prdata_next = 32'h0;
                end
            endcase
        end
    end

    // ****************************************************************
    // Transmitter
    // ****************************************************************
    // pending data
    assign tx_load = tx_en && !flags_reg.tx_empty && (tx_state_reg == SBSF_TX_IDLE);

    always_comb begin
        tx_state_next = tx_state_reg;
        tx_shift_next = tx_shift_reg;
        tx_bit_next = tx_bit_reg;
        tx_cnt_next = tx_cnt_reg;
        txd_next = txd_reg;
        unique case (tx_state_reg)
            SBSF_TX_IDLE: begin
                txd_next = 1'b1;
                if (tx_load) begin
                    tx_shift_next = {1'b1, thr_reg};
                    tx_bit_next = 4'h0;
                    tx_cnt_next = BIT_CYC;
                    txd_next = 1'b0;
                    tx_state_next = SBSF_TX_SHIFT;
                end
            end
            SBSF_TX_SHIFT: begin
                if (tx_cnt_reg != 8'h00) begin
                    tx_cnt_next = tx_cnt_reg - 8'h01;
                end else if (tx_bit_reg == 4'h9) begin
                    txd_next = 1'b1;
                    tx_state_next = SBSF_TX_IDLE;
                end else begin
                    txd_next = tx_shift_reg[0];
                    tx_shift_next = {1'b1, tx_shift_reg[8:1]};
                    tx_bit_next = tx_bit_reg + 4'h1;
                    tx_cnt_next = BIT_CYC;
                end
            end
        endcase
    end

    // ****************************************************************
    // Receiver
    // ****************************************************************
    always_comb begin
        rx_state_next = rx_state_reg;
        rx_shift_next = rx_shift_reg;
        rx_bit_next = rx_bit_reg;
        rx_cnt_next = rx_cnt_reg;
        rx_done = 1'b0;
        unique case (rx_state_reg)
            SBSF_RX_IDLE: begin
                if (re && !rxd_f) begin
                    rx_cnt_next = HALF_CYC;
                    rx_state_next = SBSF_RX_START;
                end
            end
            SBSF_RX_START: begin
                if (rx_cnt_reg != 8'h00) begin
                    rx_cnt_next = rx_cnt_reg - 8'h01;
                end else if (rxd_f) begin
                    rx_state_next = SBSF_RX_IDLE;
                end else begin
                    rx_cnt_next = BIT_CYC;
                    rx_bit_next = 4'h0;
                    rx_state_next = SBSF_RX_DATA;
                end
            end
            SBSF_RX_DATA: begin
                if (rx_cnt_reg != 8'h00) begin
                    rx_cnt_next = rx_cnt_reg - 8'h01;
                end else begin
                    rx_shift_next = {rxd_f, rx_shift_reg[7:1]};
                    rx_cnt_next = BIT_CYC;
                    rx_bit_next = rx_bit_reg + 4'h1;
                    if (rx_bit_reg == 4'h7) begin
                        rx_state_next = SBSF_RX_STOP;
                    end
                end
            end
            SBSF_RX_STOP: begin
                if (rx_cnt_reg != 8'h00) begin
                    rx_cnt_next = rx_cnt_reg - 8'h01;
                end else begin
                    // normal end only with valid stop and free buffer
                    rx_done = rxd_f && !flags_reg.rx_full;
                    rx_state_next = SBSF_RX_IDLE;
                end
            end
        endcase
    end

    // ****************************************************************
    // Registers and flags
    // ****************************************************************
    assign events = {rx_done, tx_load};

    always_comb begin
        ctrl_next = ctrl_reg;
        thr_next = thr_reg;
        rhr_next = rhr_reg;
        flags_next = flags_reg;
        arm_next = arm_reg;
        int_mask_next = int_mask_reg;
        int_stat_next = int_stat_reg;
        if (wr && paddr == `SBSF_CTRL_OFF) begin
            ctrl_next = pwdata[1:0];
        end
        if (wr && paddr == `SBSF_INT_MASK_OFF) begin
            int_mask_next = pwdata[1:0];
        end
        if (wr && paddr == `SBSF_INT_STAT_OFF) begin
            int_stat_next = int_stat_reg & ~pwdata[1:0];
        end
        // Events win over a same-cycle clear
        int_stat_next = int_stat_next | events;
        // arm on a read that returned one
        if (rd && paddr == `SBSF_STATUS_OFF) begin
            arm_next.tx_empty = arm_reg.tx_empty | prdata_reg[`SBSF_STATUS_TXE_BIT];
            arm_next.rx_full = arm_reg.rx_full | prdata_reg[`SBSF_STATUS_RXF_BIT];
        end
        if (wr && paddr == `SBSF_STATUS_OFF) begin
            arm_next = '0;
            if (arm_reg.tx_empty && !pwdata[`SBSF_STATUS_TXE_BIT]) begin
                flags_next.tx_empty = 1'b0;
            end
            if (arm_reg.rx_full && !pwdata[`SBSF_STATUS_RXF_BIT]) begin
                flags_next.rx_full = 1'b0;
            end
        end
        if (rd && paddr == `SBSF_RHR_OFF) begin
            flags_next.rx_full = 1'b0;
        end
        // handoff to shifter sets empty flag
        if (tx_load) begin
            flags_next.tx_empty = 1'b1;
        end
        if (wr && paddr == `SBSF_THR_OFF) begin
            thr_next = pwdata[7:0];
            flags_next.tx_empty = 1'b0;
        end
        if (!tx_en) begin
            flags_next.tx_empty = 1'b1;
        end
        if (rx_done) begin
            rhr_next = rx_shift_reg;
            flags_next.rx_full = 1'b1;
        end
        irq_next = |(int_stat_reg & int_mask_reg);
    end

    // ****************************************************************
    // State registers
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= `SBSF_CTRL_RST;
            flags_reg <= '{tx_empty: 1'b1, rx_full: 1'b0};
            arm_reg <= '0;
            thr_reg <= `SBSF_THR_RST;
            rhr_reg <= `SBSF_RHR_RST;
            int_stat_reg <= `SBSF_INT_RST;
            int_mask_reg <= `SBSF_INT_RST;
            irq_reg <= 1'b0;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0;
            tx_state_reg <= SBSF_TX_IDLE;
            tx_shift_reg <= 9'h1FF;
            tx_bit_reg <= 4'h0;
            tx_cnt_reg <= 8'h00;
            txd_reg <= 1'b1;
            rx_state_reg <= SBSF_RX_IDLE;
            rx_shift_reg <= 8'h00;
            rx_bit_reg <= 4'h0;
            rx_cnt_reg <= 8'h00;
        end else begin
            ctrl_reg <= ctrl_next;
            flags_reg <= flags_next;
            arm_reg <= arm_next;
            thr_reg <= thr_next;
            rhr_reg <= rhr_next;
            int_stat_reg <= int_stat_next;
            int_mask_reg <= int_mask_next;
            irq_reg <= irq_next;
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
            prdata_reg <= prdata_next;
            tx_state_reg <= tx_state_next;
            tx_shift_reg <= tx_shift_next;
            tx_bit_reg <= tx_bit_next;
            tx_cnt_reg <= tx_cnt_next;
            txd_reg <= txd_next;
            rx_state_reg <= rx_state_next;
            rx_shift_reg <= rx_shift_next;
            rx_bit_reg <= rx_bit_next;
            rx_cnt_reg <= rx_cnt_next;
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign txd = txd_reg;
    assign irq = irq_reg;

endmodule : sbsf_serial_flags

// File: testbench/sbsf_serial_flags_assertions.sv
`timescale 1ns/1ps
`include "sbsf_regs.svh"
module sbsf_serial_flags_assertions (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic rxd,
    input wire logic txd,
    input wire logic irq
);
    // ****************************************************************
    // Bus, flag and transmit line checks
    // ****************************************************************
    logic tx_en_reg;
    logic tx_en_next;
    logic rd_done;
    logic mapped;
    assign rd_done = psel && penable && pready && !pwrite;
    assign mapped = paddr[1:0] == 2'h0 && paddr <= `SBSF_INT_MASK_OFF;
    // Shadow of the transmit enable bit
    always_comb begin
        tx_en_next = tx_en_reg;
        if (psel && penable && pready && pwrite && paddr == `SBSF_CTRL_OFF) begin
            tx_en_next = pwdata[`SBSF_CTRL_TXEN_BIT];
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_en_reg <= 1'b0;
        end else begin
            tx_en_reg <= tx_en_next;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence setup_s;
        psel && !penable;
    endsequence
    sequence read_status_s;
        rd_done && paddr == `SBSF_STATUS_OFF;
    endsequence
    a_ready_after_setup: assert property (setup_s |=> pready)
        else $error("pready missing after setup");
    a_ready_in_access: assert property (pready |-> psel && penable && $past(psel && !penable))
        else $error("pready outside access phase");
    a_unmapped_error: assert property (psel && !penable && !mapped |=> pslverr)
        else $error("unmapped access without error");
    a_mapped_no_error: assert property (psel && !penable && mapped |=> !pslverr)
        else $error("error on mapped access");
    a_error_reads_zero: assert property (rd_done && pslverr |-> prdata == 32'h0)
        else $error("refused read returned data");
    a_upper_bits_zero: assert property (rd_done |-> prdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
    a_disabled_tx_empty: assert property (read_status_s ##0 !tx_en_reg |-> prdata[7])
        else $error("empty flag low with transmit disabled");
    a_start_bit_low: assert property ($fell(txd) |-> (!txd) [*8])
        else $error("start bit too short");
    a_reset_quiet: assert property ($rose(presetn) |-> txd && !irq && !pready)
        else $error("outputs not idle after reset");
endmodule : sbsf_serial_flags_assertions

bind sbsf_serial_flags sbsf_serial_flags_assertions u_sbsf_serial_flags_assertions (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rxd(rxd), .txd(txd), .irq(irq)
);

// File: testbench/sbsf_serial_flags_tb.sv
`timescale 1ns/1ps
`include "sbsf_regs.svh"
module sbsf_serial_flags_tb;
    // ****************************************************************
    // Bench
    // ****************************************************************
    logic pclk = 1'b0;
    logic presetn, psel, penable, pwrite, pready, pslverr, rxd, txd, irq, rd_err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd_data;
    int fail_count = 0;
    int comparisons = 0;
    always #5 pclk = ~pclk;
    sbsf_serial_flags u_sbsf_serial_flags (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rxd(rxd), .txd(txd), .irq(irq));
    sbsf_serial_peer u_sbsf_serial_peer (.pclk(pclk), .txd(txd), .rxd(rxd));
    task automatic close_out;
        $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : close_out
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd_data = prdata;
        rd_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd_data, exp);
    endtask : rd
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    initial begin
        repeat (20000) @(posedge pclk);
        fail_count++;
        close_out();
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rd(`SBSF_STATUS_OFF, 32'h80);
        rd(`SBSF_CTRL_OFF, 32'h0);
        rd(`SBSF_RHR_OFF, 32'h0);
        wr(`SBSF_CTRL_OFF, 32'h1);
        wr(`SBSF_STATUS_OFF, 32'hC0);
        wr(`SBSF_STATUS_OFF, 32'h0);
        rd(`SBSF_INT_STAT_OFF, 32'h0);
        rd(`SBSF_STATUS_OFF, 32'h80);
        wr(`SBSF_STATUS_OFF, 32'h0);
        rd(`SBSF_INT_STAT_OFF, 32'h1);
        rd(`SBSF_STATUS_OFF, 32'h80);
        wr(`SBSF_INT_STAT_OFF, 32'h1);
        wr(`SBSF_THR_OFF, 32'h5A);
        rd(`SBSF_STATUS_OFF, 32'h0);
        wr(`SBSF_STATUS_OFF, 32'h80);
        rd(`SBSF_STATUS_OFF, 32'h0);
        wr(`SBSF_CTRL_OFF, 32'h0);
        rd(`SBSF_STATUS_OFF, 32'h80);
        while (u_sbsf_serial_peer.rx_q.size() < 1) @(posedge pclk);
        repeat (80) @(posedge pclk);
        chk(u_sbsf_serial_peer.rx_q.pop_front(), 32'h0);
        wr(`SBSF_CTRL_OFF, 32'h3);
        wr(`SBSF_THR_OFF, 32'hA5);
        wr(`SBSF_THR_OFF, 32'h3C);
        rd(`SBSF_STATUS_OFF, 32'h0);
        rd(`SBSF_THR_OFF, 32'h0);
        while (u_sbsf_serial_peer.rx_q.size() < 1) @(posedge pclk);
        repeat (80) @(posedge pclk);
        rd(`SBSF_STATUS_OFF, 32'h80);
        while (u_sbsf_serial_peer.rx_q.size() < 2) @(posedge pclk);
        chk(u_sbsf_serial_peer.rx_q[0], 32'hA5);
        chk(u_sbsf_serial_peer.rx_q[1], 32'h3C);
        rd(`SBSF_INT_STAT_OFF, 32'h1);
        chk(irq, 1'b0);
        wr(`SBSF_INT_MASK_OFF, 32'h3);
        repeat (3) @(posedge pclk);
        chk(irq, 1'b1);
        wr(`SBSF_INT_STAT_OFF, 32'h1);
        repeat (3) @(posedge pclk);
        chk(irq, 1'b0);
        u_sbsf_serial_peer.send(8'h5A, 1'b1);
        rd(`SBSF_STATUS_OFF, 32'hC0);
        chk(irq, 1'b1);
        rd(`SBSF_RHR_OFF, 32'h5A);
        rd(`SBSF_STATUS_OFF, 32'h80);
        wr(`SBSF_INT_STAT_OFF, 32'h2);
        rd(`SBSF_INT_STAT_OFF, 32'h0);
        u_sbsf_serial_peer.send(8'h96, 1'b1);
        rd(`SBSF_STATUS_OFF, 32'hC0);
        wr(`SBSF_STATUS_OFF, 32'h80);
        rd(`SBSF_STATUS_OFF, 32'h80);
        rd(`SBSF_RHR_OFF, 32'h96);
        u_sbsf_serial_peer.send(8'h11, 1'b0);
        rd(`SBSF_STATUS_OFF, 32'h80);
        rd(`SBSF_RHR_OFF, 32'h96);
        wr(`SBSF_CTRL_OFF, 32'h1);
        u_sbsf_serial_peer.send(8'h77, 1'b1);
        rd(`SBSF_STATUS_OFF, 32'h80);
        rd(8'h20, 32'h0);
        chk(rd_err, 1'b1);
        wr(8'h18, 32'hFF);
        chk(rd_err, 1'b1);
        close_out();
    end
endmodule : sbsf_serial_flags_tb

// File: testbench/sbsf_serial_peer.sv
`timescale 1ns/1ps
`include "sbsf_regs.svh"
module sbsf_serial_peer (
    input wire logic pclk,
    input wire logic txd,
    output logic rxd
);
    // ****************************************************************
    // Remote transmitter and receiver
    // ****************************************************************
    logic [7:0] rx_q[$];
    logic [7:0] sh;
    initial rxd = 1'b1;
    // Frame with a chosen stop level, idle high after
    task automatic send(input logic [7:0] b, input logic stop);
        @(posedge pclk);
        rxd <= 1'b0;
        repeat (`SBSF_BIT_CYCLES) @(posedge pclk);
        for (int i = 0; i < 8; i++) begin
            rxd <= b[i];
            repeat (`SBSF_BIT_CYCLES) @(posedge pclk);
        end
        rxd <= stop;
        repeat (`SBSF_BIT_CYCLES) @(posedge pclk);
        rxd <= 1'b1;
        repeat (`SBSF_BIT_CYCLES) @(posedge pclk);
    endtask : send
    // Samples at bit centres, keeps only well framed bytes
    initial begin
        forever begin
            @(negedge txd);
            repeat (`SBSF_HALF_CYCLES) @(posedge pclk);
            for (int i = 0; i < 8; i++) begin
                repeat (`SBSF_BIT_CYCLES) @(posedge pclk);
                sh[i] = txd;
            end
            repeat (`SBSF_BIT_CYCLES) @(posedge pclk);
            if (txd === 1'b1) begin
                rx_q.push_back(sh);
            end
        end
    end
endmodule : sbsf_serial_peer
